// ---- hdl/tio_defines.svh ----
// Contract
// - batch capture copies transmit stream to accessories
// - keyboard print data goes to cassette and printer
// - received data forwarded only with DSR, no print
// - half duplex transmit blocks received data
// - latch seven character bits on load edge
// - shift-load rise fires load pulse when qualified
// - latch clock needs idle cassette and printer gate
// - control period slash puts printer on line
// - control period question mark takes printer offline
// - processor reset low forces printer off line
// - one character per latch clock
// - cassette enable on receive-mode playback or on record outside print mode
// - bit clock and transmit inverted to cassette
// - ack-fired pulse with control enable sends ack
// - ack-fired pulse copied inverted to cassette
// - receive input picks line or playback data
// - receive data ORed with clock phase qualifier
// - baud clock inhibit on four conditions
// - register clock from three sources
// - print/record flag on record with no print request
// - transmit permit low only for receive conditions
// - transmit-or-print request returned as acknowledge
`ifndef TIO_DEFINES_SVH
`define TIO_DEFINES_SVH

// clock and one-shot timing
`define TIO_CLK_MHZ          125
`define TIO_LOAD_PULSE_NS    1000
`define TIO_LOAD_PULSE_CYC   ((`TIO_LOAD_PULSE_NS * `TIO_CLK_MHZ + 999) / 1000)
`define TIO_PULSE_CNT_W      8

// widths, synchroniser layout and off-line reset value
`define TIO_CHAR_W           7
`define TIO_SYNC_N           12
`define TIO_OFFLINE_RST      1'h1

// character bit positions of the control sequence
`define TIO_BIT5_POS         4
`define TIO_BIT6_POS         5
`define TIO_BIT7_POS         6

`endif

// ---- hdl/tio_pkg.sv ----
package tio_pkg;

    // one-shot state
    typedef enum logic {
        TIO_PULSE_IDLE,
        TIO_PULSE_RUN
    } tio_pulse_state_t;

    // what fired the load pulse
    typedef enum logic {
        TIO_SRC_SHIFT,
        TIO_SRC_ACK
    } tio_fire_src_t;

endpackage : tio_pkg

// ---- hdl/tio_pulse.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tio_defines.svh"

module tio_pulse
    import tio_pkg::*;
(
    // clock and reset
    input  wire logic core_clk,
    input  wire logic sys_rst,
    // trigger and pulse
    input  wire logic trig,
    output logic      pulse,
    output logic      done
);

    localparam logic [`TIO_PULSE_CNT_W-1:0] LAST = `TIO_PULSE_CNT_W'(`TIO_LOAD_PULSE_CYC - 1);

    tio_pulse_state_t             state_q;
    tio_pulse_state_t             state_d;
    logic [`TIO_PULSE_CNT_W-1:0]  cnt_q;
    logic [`TIO_PULSE_CNT_W-1:0]  cnt_d;
    wire                          at_end = (cnt_q == LAST);

    // fixed-length pulse, retriggers ignored while running
    always_comb
    begin
        state_d = state_q;
        cnt_d   = cnt_q;
        unique case (state_q)
            TIO_PULSE_IDLE:
            begin
                cnt_d = '0;
                if (trig)
                    state_d = TIO_PULSE_RUN;
            end
            TIO_PULSE_RUN:
            begin
                cnt_d = cnt_q + 1'b1;
                if (at_end)
                    state_d = TIO_PULSE_IDLE;
            end
        endcase
    end

    // state and counter
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_q <= TIO_PULSE_IDLE;
            cnt_q   <= '0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    assign pulse = (state_q == TIO_PULSE_RUN);
    assign done  = pulse && at_end;

    // helper: length of the current run of pulse cycles, independent of cnt_q
    localparam logic [`TIO_PULSE_CNT_W-1:0] LEN = `TIO_PULSE_CNT_W'(`TIO_LOAD_PULSE_CYC);
    logic [`TIO_PULSE_CNT_W-1:0]  run_q;

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            run_q <= '0;
        else if (pulse)
            run_q <= run_q + 1'b1;
        else
            run_q <= '0;
    end

    // pulse lasts exactly the programmed count
    pulse_len_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        $fell(pulse) |-> run_q == LEN)
        else $error("load pulse length wrong");

    pulse_max_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        pulse |-> run_q < LEN)
        else $error("load pulse runs too long");

endmodule : tio_pulse
`default_nettype wire

// ---- hdl/tio_router.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tio_defines.svh"

module tio_router
    import tio_pkg::*;
(
    // clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   sys_rst,
    // processor serial data and modes
    input  wire logic                   tx_serial,
    input  wire logic                   print_serial,
    input  wire logic                   hdx_serial,
    input  wire logic                   batch_capture,
    input  wire logic                   half_duplex_tx,
    input  wire logic                   print_cmd,
    input  wire logic                   print_mode,
    input  wire logic                   print_n,
    input  wire logic                   recv_mode,
    input  wire logic                   proc_reset_n,
    // processor load and character controls
    input  wire logic                   shift_load_en,
    input  wire logic                   sequencer_active_n,
    input  wire logic                   send_or_hardcopy_n,
    input  wire logic                   rx_char_ack_n,
    input  wire logic                   ctrl_func_en,
    input  wire logic                   row_sel_n,
    input  wire logic [`TIO_CHAR_W-1:0] char_bits,
    // processor clocks
    input  wire logic                   proc_bit_clk,
    input  wire logic                   transmit_active,
    input  wire logic                   int_reg_clk,
    input  wire logic                   phase_t06,
    // modem
    input  wire logic                   modem_rx_data,
    input  wire logic                   modem_dsr,
    input  wire logic                   modem_cts,
    // cassette
    input  wire logic                   cass_playback,
    input  wire logic                   cass_record,
    input  wire logic                   cass_tape_clk,
    input  wire logic                   cass_play_data,
    // printer
    input  wire logic                   prn_mode_n,
    input  wire logic                   prn_inhibit_clk_n,
    input  wire logic                   prn_busy,
    input  wire logic                   prn_online_sw_n,
    input  wire logic                   prn_serial_online,
    // outputs to cassette
    output logic                        cass_data,
    output logic                        cass_enable_n,
    output logic                        cassette_bit_clk_out,
    output logic                        cass_transmit_active_n,
    output logic                        cass_ctrl_ack_n,
    output logic                        cass_load_n,
    // outputs to printer
    output logic                        prn_serial,
    output logic [`TIO_CHAR_W-1:0]      prn_par_data,
    output logic                        prn_strobe,
    output logic                        prn_online_led,
    // outputs to processor
    output logic                        rx_to_proc,
    output logic                        rx_qual,
    output logic                        baud_inhibit_n,
    output logic                        shift_reg_clk,
    output logic                        send_or_hardcopy_ack,
    output logic                        print_record,
    output logic                        tx_permit
);

    // synchronise the outside parties' inputs
    wire  [`TIO_SYNC_N-1:0] raw_in = {modem_rx_data, modem_dsr, modem_cts, cass_playback,
                                      cass_record, cass_tape_clk, cass_play_data, prn_mode_n,
                                      prn_inhibit_clk_n, prn_busy, prn_online_sw_n,
                                      prn_serial_online};
    logic [`TIO_SYNC_N-1:0] sync1_q;
    logic [`TIO_SYNC_N-1:0] sync2_q;

    genvar gi;
    generate
        for (gi = 0; gi < `TIO_SYNC_N; gi++)
        begin : g_sync
            always_ff @(posedge core_clk or posedge sys_rst)
            begin
                if (sys_rst)
                begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                end
                else
                begin
                    sync1_q[gi] <= raw_in[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate

    // unpack synchronised inputs
    wire s_rx      = sync2_q[11];
    wire s_dsr     = sync2_q[10];
    wire s_cts     = sync2_q[9];
    wire s_play    = sync2_q[8];
    wire s_rec     = sync2_q[7];
    wire s_tclk    = sync2_q[6];
    wire s_pdata   = sync2_q[5];
    wire s_pmode_n = sync2_q[4];
    wire s_pinh_n  = sync2_q[3];
    wire s_busy    = sync2_q[2];
    wire s_psw_n   = sync2_q[1];
    wire s_ser_on  = sync2_q[0];

    // edge history for processor strobes
    logic shift_load_q;
    logic ack_n_q;
    logic pulse_q;
    logic offline_q;
    logic edge_pend_q;
    tio_fire_src_t src_q;

    // mode qualifiers
    wire print_qual  = ~(print_cmd | print_mode);
    wire rx_fwd      = s_rx & s_dsr & print_qual & ~half_duplex_tx;
    wire rx_line     = (s_rx & s_dsr & ~half_duplex_tx) | (half_duplex_tx & hdx_serial);
    wire acc_data    = rx_fwd | (half_duplex_tx & hdx_serial) | (batch_capture & tx_serial);
    wire cass_idle   = ~s_play & ~s_rec;
    wire local_gate  = cass_idle & ~print_n & ~s_pmode_n;
    wire online      = ~offline_q | ~s_psw_n;
    wire latch_gate  = cass_idle & (online | local_gate);
    wire play_en_n   = ~(recv_mode & s_play);
    wire cass_en     = (recv_mode & s_play) | (s_rec & ~print_mode);

    // load pulse triggers
    wire shift_fire  = shift_load_en & ~shift_load_q & (~sequencer_active_n | ~send_or_hardcopy_n);
    wire ack_fire    = ~rx_char_ack_n & ack_n_q;
    wire fire        = shift_fire | ack_fire;
    wire pulse;
    wire pulse_done;
    wire pulse_rise  = pulse & ~pulse_q;
    wire pulse_fall  = ~pulse & pulse_q;
    wire latch_clk   = pulse_rise & latch_gate;

    // control sequence decode
    wire ctl_seq     = ctrl_func_en & ~char_bits[`TIO_BIT7_POS] & char_bits[`TIO_BIT6_POS] & ~row_sel_n;
    wire go_online   = pulse_rise & ctl_seq & ~char_bits[`TIO_BIT5_POS];
    wire go_offline  = pulse_rise & ctl_seq & char_bits[`TIO_BIT5_POS];

    tio_pulse u_pulse (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .trig     (fire),
        .pulse    (pulse),
        .done     (pulse_done)
    );

    // strobe edge tracking
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            shift_load_q <= 1'b0;
            ack_n_q      <= 1'b1;
            pulse_q      <= 1'b0;
        end
        else
        begin
            shift_load_q <= shift_load_en;
            ack_n_q      <= rx_char_ack_n;
            pulse_q      <= pulse;
        end
    end

    // remember the source of the running pulse
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            src_q <= TIO_SRC_SHIFT;
        else if (fire && !pulse)
            src_q <= ack_fire ? TIO_SRC_ACK : TIO_SRC_SHIFT;
    end

    // printer off-line flag, reset or offline command sets it
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            offline_q <= `TIO_OFFLINE_RST;
        else if (!proc_reset_n || go_offline)
            offline_q <= 1'b1;
        else if (go_online)
            offline_q <= 1'b0;
    end

    // parallel character latch and one strobe per latch clock
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            prn_par_data <= '0;
            prn_strobe   <= 1'b0;
        end
        else
        begin
            if (latch_clk)
                prn_par_data <= char_bits;
            prn_strobe <= latch_clk;
        end
    end

    // pending load-pulse edge awaiting the clock phase
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            edge_pend_q <= 1'b0;
        else if (pulse_rise || pulse_fall)
            edge_pend_q <= 1'b1;
        else if (phase_t06)
            edge_pend_q <= 1'b0;
    end

    // registered receive data to the processor
    wire rx_sel = play_en_n ? rx_line : s_pdata;
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            rx_to_proc <= 1'b0;
        else
            rx_to_proc <= rx_sel;
    end

    // serial accessory paths
    assign cass_data            = s_rec & (acc_data | print_serial);
    assign prn_serial           = (acc_data & s_ser_on) | print_serial;

    // cassette controls and printer on-line indicator
    assign cass_enable_n        = ~cass_en;
    assign cassette_bit_clk_out = ~proc_bit_clk;
    assign cass_transmit_active_n          = ~transmit_active;
    assign cass_ctrl_ack_n      = ~(pulse & (src_q == TIO_SRC_ACK) & ctrl_func_en);
    assign cass_load_n          = ~(pulse & (src_q == TIO_SRC_ACK));
    assign prn_online_led       = ~offline_q;

    // processor returns
    assign rx_qual              = rx_to_proc | phase_t06;
    assign baud_inhibit_n       = ~((~print_n & ~s_pinh_n) | ~play_en_n | cass_en | local_gate);
    assign shift_reg_clk        = int_reg_clk | s_tclk |
                                  (local_gate & s_busy & edge_pend_q & phase_t06);
    assign print_record         = print_qual & s_rec;
    assign tx_permit            = ~(s_dsr & print_qual & ~s_cts);
    assign send_or_hardcopy_ack = (online | ~s_busy) & tx_permit & ~send_or_hardcopy_n;

    // assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence s_online_cmd;
        pulse_rise && ctl_seq && !char_bits[`TIO_BIT5_POS] && proc_reset_n;
    endsequence
    sequence s_led_lit;
        prn_online_led && !offline_q;
    endsequence

    online_cmd_a: assert property (s_online_cmd |=> s_led_lit)
        else $error("online command did not light indicator");

    offline_cmd_a: assert property (go_offline |=> !prn_online_led)
        else $error("offline command left indicator lit");

    proc_reset_a: assert property (!proc_reset_n |=> offline_q)
        else $error("processor reset did not force offline");

    latch_data_a: assert property (latch_clk |=> prn_strobe && prn_par_data == $past(char_bits))
        else $error("character not latched on load edge");

    latch_gate_a: assert property (prn_strobe |-> $past(cass_idle) && $past(pulse_rise))
        else $error("latch clocked while cassette busy");

    one_strobe_a: assert property (prn_strobe |=> !prn_strobe)
        else $error("more than one strobe per latch clock");

    shift_fire_a: assert property (shift_fire && !pulse |=> pulse)
        else $error("shift load edge did not fire pulse");

    ack_copy_a: assert property (ack_fire && !pulse |=> !cass_load_n [*2])
        else $error("ack pulse not copied to cassette");

    rx_block_a: assert property (half_duplex_tx |-> !rx_fwd)
        else $error("received data passed during half duplex send");

    rx_select_a: assert property (!play_en_n |=> rx_to_proc == $past(s_pdata))
        else $error("playback data not routed to processor");

    permit_a: assert property (!tx_permit |-> s_dsr && !s_cts && print_qual)
        else $error("transmit permit dropped wrongly");

    pulse_end_a: assert property (pulse_done |=> !pulse)
        else $error("load pulse outlived its last cycle");

endmodule : tio_router
`default_nettype wire

// ---- test/tio_far_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module tio_far_model (
    // clock and far-side selections from the bench
    input  wire logic core_clk,
    input  wire logic play_sel,
    input  wire logic rec_sel,
    input  wire logic mode_n_sel,
    // modem
    output logic      modem_rx_data,
    output logic      modem_dsr,
    output logic      modem_cts,
    // cassette
    output logic      cass_playback,
    output logic      cass_record,
    output logic      cass_tape_clk,
    output logic      cass_play_data,
    // printer
    output logic      prn_mode_n,
    output logic      prn_inhibit_clk_n,
    output logic      prn_busy,
    output logic      prn_online_sw_n,
    output logic      prn_serial_online
);
    logic tog = 1'h0;

    // data lines move every cycle so no stale level can pass for data
    always @(negedge core_clk)
    begin
        tog <= ~tog;
    end

    // idle modem, tape clock standing still, printer not forced on line
    assign modem_rx_data     = tog;
    assign cass_play_data    = ~tog;
    assign modem_dsr         = 1'h0;
    assign modem_cts         = 1'h0;
    assign cass_tape_clk     = 1'h0;
    assign cass_playback     = play_sel;
    assign cass_record       = rec_sel;
    assign prn_mode_n        = mode_n_sel;
    assign prn_inhibit_clk_n = 1'h1;
    assign prn_busy          = 1'h0;
    assign prn_online_sw_n   = 1'h1;
    assign prn_serial_online = 1'h0;
endmodule : tio_far_model

`default_nettype wire

// ---- test/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tio_defines.svh"

module tb;
    // processor side stimulus
    logic core_clk = 1'h0, sys_rst = 1'h1, print_n = 1'h1, proc_reset_n = 1'h1;
    logic tx_serial = 1'h0, print_serial = 1'h0, hdx_serial = 1'h0, batch_capture = 1'h0;
    logic half_duplex_tx = 1'h0, print_cmd = 1'h0, print_mode = 1'h0, recv_mode = 1'h0, int_reg_clk = 1'h0;
    logic shift_load_en = 1'h0, sequencer_active_n = 1'h1, send_or_hardcopy_n = 1'h1, rx_char_ack_n = 1'h1;
    logic ctrl_func_en = 1'h0, row_sel_n = 1'h1, proc_bit_clk = 1'h0, transmit_active = 1'h0, phase_t06 = 1'h0;
    logic [`TIO_CHAR_W-1:0] char_bits = 7'h00, prn_par_data;
    logic play_sel = 1'h0, rec_sel = 1'h0, mode_n_sel = 1'h1;
    // far side and design outputs
    logic modem_rx_data, modem_dsr, modem_cts, cass_playback, cass_record, cass_tape_clk, cass_play_data;
    logic prn_mode_n, prn_inhibit_clk_n, prn_busy, prn_online_sw_n, prn_serial_online;
    logic cass_data, cass_enable_n, cassette_bit_clk_out, cass_transmit_active_n, cass_ctrl_ack_n, cass_load_n;
    logic prn_serial, prn_strobe, prn_online_led, rx_to_proc, rx_qual, baud_inhibit_n, shift_reg_clk;
    logic send_or_hardcopy_ack, print_record, tx_permit;
    // reference model state
    int     n_mismatch = 0, num_checks = 0, cyc = 0;
    logic   hd_prev = 1'h0;
    integer seed = 32'hD1640B5A;
    logic [`TIO_CHAR_W-1:0] exp_q[$];

    tio_far_model far_u (.core_clk(core_clk), .play_sel(play_sel), .rec_sel(rec_sel), .mode_n_sel(mode_n_sel),
        .modem_rx_data(modem_rx_data), .modem_dsr(modem_dsr), .modem_cts(modem_cts),
        .cass_playback(cass_playback), .cass_record(cass_record), .cass_tape_clk(cass_tape_clk),
        .cass_play_data(cass_play_data), .prn_mode_n(prn_mode_n), .prn_inhibit_clk_n(prn_inhibit_clk_n),
        .prn_busy(prn_busy), .prn_online_sw_n(prn_online_sw_n), .prn_serial_online(prn_serial_online));

    tio_router dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .tx_serial(tx_serial),
        .print_serial(print_serial), .hdx_serial(hdx_serial), .batch_capture(batch_capture),
        .half_duplex_tx(half_duplex_tx), .print_cmd(print_cmd), .print_mode(print_mode), .print_n(print_n),
        .recv_mode(recv_mode), .proc_reset_n(proc_reset_n), .shift_load_en(shift_load_en),
        .sequencer_active_n(sequencer_active_n), .send_or_hardcopy_n(send_or_hardcopy_n),
        .rx_char_ack_n(rx_char_ack_n), .ctrl_func_en(ctrl_func_en), .row_sel_n(row_sel_n),
        .char_bits(char_bits), .proc_bit_clk(proc_bit_clk), .transmit_active(transmit_active),
        .int_reg_clk(int_reg_clk), .phase_t06(phase_t06), .modem_rx_data(modem_rx_data),
        .modem_dsr(modem_dsr), .modem_cts(modem_cts), .cass_playback(cass_playback),
        .cass_record(cass_record), .cass_tape_clk(cass_tape_clk), .cass_play_data(cass_play_data),
        .prn_mode_n(prn_mode_n), .prn_inhibit_clk_n(prn_inhibit_clk_n), .prn_busy(prn_busy),
        .prn_online_sw_n(prn_online_sw_n), .prn_serial_online(prn_serial_online), .cass_data(cass_data),
        .cass_enable_n(cass_enable_n), .cassette_bit_clk_out(cassette_bit_clk_out),
        .cass_transmit_active_n(cass_transmit_active_n), .cass_ctrl_ack_n(cass_ctrl_ack_n), .cass_load_n(cass_load_n),
        .prn_serial(prn_serial), .prn_par_data(prn_par_data), .prn_strobe(prn_strobe),
        .prn_online_led(prn_online_led), .rx_to_proc(rx_to_proc), .rx_qual(rx_qual),
        .baud_inhibit_n(baud_inhibit_n), .shift_reg_clk(shift_reg_clk),
        .send_or_hardcopy_ack(send_or_hardcopy_ack), .print_record(print_record), .tx_permit(tx_permit));

    // compare and count
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask : check

    // verdict and end of run
    task automatic end_sim;
        if (n_mismatch == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim

    // one load trigger held past the pulse, counting low cycles of the cassette acks
    task automatic fire(input logic ack, input logic [6:0] ch, input logic latch);
        int nl;
        int na;
        nl = 0;
        na = 0;
        @(negedge core_clk);
        char_bits = ch;
        if (latch)
            exp_q.push_back(ch);
        if (ack)
            rx_char_ack_n = 1'h0;
        else
            shift_load_en = 1'h1;
        repeat (130)
        begin
            @(negedge core_clk);
            nl += int'(cass_load_n === 1'h0);
            na += int'(cass_ctrl_ack_n === 1'h0);
        end
        shift_load_en = 1'h0;
        rx_char_ack_n = 1'h1;
        repeat (2) @(negedge core_clk);
        check("cass_load_n low", 8'(nl), ack ? 8'h7D : 8'h00);
        check("cass_ctrl_ack_n low", 8'(na), (ack && ctrl_func_en) ? 8'h7D : 8'h00);
    endtask : fire

    // print_n and far-side setting change, then wait out the synchroniser
    task automatic settle(input logic pn, input logic mn, input logic ps, input logic rs);
        print_n = pn;
        mode_n_sel = mn;
        play_sel = ps;
        rec_sel = rs;
        repeat (4) @(negedge core_clk);
    endtask : settle

    always #4 core_clk = ~core_clk;

    // hang guard
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            n_mismatch++;
            end_sim();
        end
    end

    // seeded levels on the remaining processor inputs
    always @(negedge core_clk)
    begin
        {tx_serial, print_serial, hdx_serial, batch_capture, half_duplex_tx, print_cmd, print_mode, recv_mode,
         int_reg_clk} = 9'($random(seed));
    end

    // each strobe must carry the oldest expected character
    always @(negedge core_clk)
    begin
        if (prn_strobe === 1'h1)
        begin
            if (exp_q.size() == 0)
                check("unexpected strobe", 8'h01, 8'h00);
            else
                check("prn_par_data", {1'h0, prn_par_data}, {1'h0, exp_q.pop_front()});
        end
    end

    // main sequence
    initial
    begin
        repeat (12) @(negedge core_clk);
        check("led in reset", {7'h00, prn_online_led}, 8'h00);
        check("data in reset", {1'h0, prn_par_data}, 8'h00);
        sys_rst = 1'h0;
        repeat (4) @(negedge core_clk);
        sequencer_active_n = 1'h0;
        fire(1'h0, 7'h41, 1'h0);
        settle(1'h0, 1'h0, 1'h0, 1'h0);
        repeat (4) fire(1'h0, 7'($random(seed)), 1'h1);
        sequencer_active_n = 1'h1;
        fire(1'h0, 7'h33, 1'h0);
        send_or_hardcopy_n = 1'h0;
        fire(1'h0, 7'h7F, 1'h1);
        fire(1'h1, 7'h0C, 1'h1);
        ctrl_func_en = 1'h1;
        row_sel_n = 1'h0;
        fire(1'h0, 7'h20, 1'h1);
        check("led on", {7'h00, prn_online_led}, 8'h01);
        settle(1'h1, 1'h1, 1'h0, 1'h0);
        fire(1'h0, 7'h55, 1'h1);
        settle(1'h0, 1'h0, 1'h0, 1'h0);
        fire(1'h0, 7'h30, 1'h1);
        check("led off", {7'h00, prn_online_led}, 8'h00);
        settle(1'h1, 1'h1, 1'h0, 1'h0);
        fire(1'h0, 7'h4A, 1'h0);
        settle(1'h0, 1'h0, 1'h1, 1'h0);
        fire(1'h0, 7'h11, 1'h0);
        settle(1'h0, 1'h0, 1'h0, 1'h1);
        fire(1'h0, 7'h12, 1'h0);
        settle(1'h0, 1'h0, 1'h0, 1'h0);
        row_sel_n = 1'h1;
        fire(1'h1, 7'h00, 1'h1);
        row_sel_n = 1'h0;
        fire(1'h0, 7'h20, 1'h1);
        proc_reset_n = 1'h0;
        @(negedge core_clk);
        proc_reset_n = 1'h1;
        repeat (2) @(negedge core_clk);
        check("led after proc reset", {7'h00, prn_online_led}, 8'h00);
        for (int r = 0; r < 2; r++)
        begin
            settle(1'h0, 1'h0, 1'h0, r[0]);
            for (int i = 0; i < 16; i++)
            begin
                @(negedge core_clk);
                {proc_bit_clk, transmit_active, phase_t06} = 3'($random(seed));
                #1;
                check("bit clk", {7'h00, cassette_bit_clk_out}, {7'h00, ~proc_bit_clk});
                check("transmit_active", {7'h00, cass_transmit_active_n}, {7'h00, ~transmit_active});
                if (i > 0 || phase_t06)
                    check("rx_qual", {7'h00, rx_qual}, {7'h00, phase_t06 | (hd_prev & (i > 0))});
                if (i > 0)
                    check("rx_to_proc", {7'h00, rx_to_proc}, {7'h00, hd_prev});
                check("cass_enable_n", {7'h00, cass_enable_n}, {7'h00, ~(r[0] & ~print_mode)});
                check("print_record", {7'h00, print_record}, {7'h00, r[0] & ~print_cmd & ~print_mode});
                check("cass_data", {7'h00, cass_data},
                      {7'h00, r[0] & (print_serial | (batch_capture & tx_serial) | (half_duplex_tx & hdx_serial))});
                check("prn_serial", {7'h00, prn_serial}, {7'h00, print_serial});
                check("baud_inhibit_n", {7'h00, baud_inhibit_n}, {7'h00, r[0] & print_mode});
                check("shift_reg_clk", {7'h00, shift_reg_clk}, {7'h00, int_reg_clk});
                check("tx_permit", {7'h00, tx_permit}, 8'h01);
                check("send_or_hardcopy_ack", {7'h00, send_or_hardcopy_ack}, {7'h00, ~send_or_hardcopy_n});
                hd_prev = half_duplex_tx & hdx_serial;
            end
        end
        check("chars pending", 8'(exp_q.size()), 8'h00);
        end_sim();
    end
endmodule : tb

`default_nettype wire
